// >>> sucr_pkg.sv
// Constants shared by the sensor user configuration register bank.
// Assumes an AXI4-Lite master with 32-bit data and 8-bit byte addresses.
package sucr_pkg;

  // Byte addresses of the software-visible registers.
  localparam int         ADDR_W         = 8;
  localparam logic [7:0] OFF_MEAS_CTRL  = 8'h00;
  localparam logic [7:0] OFF_AUX_CTRL   = 8'h04;
  localparam logic [7:0] OFF_HEAT_CTRL  = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;

  // Field positions of the measurement control register.
  localparam int BIT_RES_HI  = 7;
  localparam int BIT_SUPPLY  = 6;
  localparam int BIT_HEAT_ON = 2;
  localparam int BIT_RES_LO  = 0;

  // Field positions of the auxiliary input control register.
  localparam int BIT_NO_HOLD = 6;
  localparam int BIT_THERM   = 5;
  localparam int BIT_SPEED   = 4;
  localparam int BIT_BUF     = 2;
  localparam int BIT_VREF    = 1;
  localparam int BIT_DRIVE   = 0;

  // Heater level field width.
  localparam int HEAT_LVL_W = 4;

  // Reserved bit masks and the values they always read back as.
  localparam logic [7:0] RESERVED_BITS_MASK_1 = 8'h3a;
  localparam logic [7:0] RESERVED_BITS_VAL_1  = 8'h3a;
  localparam logic [7:0] RESERVED_BITS_MASK_2 = 8'h88;
  localparam logic [7:0] RESERVED_BITS_VAL_2  = 8'h08;
  localparam logic [7:0] RESERVED_BITS_MASK_3 = 8'hf0;
  localparam logic [7:0] RESERVED_BITS_VAL_3  = 8'h00;

  // Reset values of the writable fields.
  localparam logic [1:0]            RST_RES      = 2'h0;
  localparam logic                  RST_HEAT_ON  = 1'b0;
  localparam logic [5:0]            RST_AUX_BITS = 6'h00;
  localparam logic [HEAT_LVL_W-1:0] RST_HEAT_LVL = 4'h0;

  // Interrupt status bit positions.
  localparam int IRQ_W      = 3;
  localparam int IRQ_SUPPLY = 0;
  localparam int IRQ_BADWR  = 1;
  localparam int IRQ_MEAS   = 2;

  // Resolution code to humidity and temperature bit counts.
  localparam logic [3:0] RES_RH_BITS [0:3] = '{4'hc, 4'h8, 4'ha, 4'hb};
  localparam logic [3:0] RES_T_BITS  [0:3] = '{4'he, 4'hc, 4'hd, 4'hb};

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Edges after reset release before the synchronised pin level is valid.
  localparam logic [1:0] STRAP_WAIT = 2'h3;

endpackage : sucr_pkg

// >>> sucr_sync_edge.sv
// Two-flop synchroniser with a rising edge detector, one lane per bit.
// Assumes the inputs are asynchronous to aclk and slow against it.
`timescale 1ns/1ps
module sucr_sync_edge #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sucr_sync_t;

  sucr_sync_t s_q;
  sucr_sync_t s_d;

  initial
  begin
    if (W < 1) $error("sucr_sync_edge needs at least one lane.");
  end

  // The first stage feeds only the second, so a metastable value never spreads.
  always_comb
  begin
    s_d    = s_q;
    s_d.s1 = async_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  // State register.
  always_ff @(posedge aclk)
  begin
    if (!aresetn) s_q <= '0;
    else          s_q <= s_d;
  end

  // Level and edge are taken from the settled stages only.
  assign level = s_q.s2;
  assign rise  = s_q.s2 & ~s_q.s3;

endmodule : sucr_sync_edge

// >>> sucr_regs.sv
// Sensor user configuration registers behind an AXI4-Lite slave.
// Assumes supply_low_in, the pin input, link_clk and meas_req_in are asynchronous.
// Operation
// - Reserved bits read as their fixed value and ignore writes.
// - Resolution code picks humidity and temperature bit counts.
// - Supply flag is read-only, high while supply sits in the low band.
// - Heater enable bit switches the on-chip heater.
// - No-hold bit selects no-hold mode for auxiliary measurements.
// - Correction bit applies thermistor correction to auxiliary results.
// - Speed bit picks normal or fast voltage conversion.
// - Buffer bit routes auxiliary inputs through buffers.
// - Reference bit picks internal reference or analog supply.
// - Drive bit sets the dual-function pin low or high.
// - Auxiliary register resets to 0000100x, drive bit from pin level.
// - Pin is sampled as address bit at power-up, then driven.
// - Heater level field selects one of sixteen currents.
// - Heater register resets to zero, measurement register to 0x3a.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module sucr_regs
  import sucr_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  supply_low_in,
  input  wire logic                  link_clk,
  input  wire logic                  meas_req_in,
  input  wire logic                  pin_in,
  output logic                       pin_out,
  output logic                       pin_oe,
  output logic                       addr_lsb,
  output logic                       strap_done,
  output logic [1:0]                 resolution_select,
  output logic [3:0]                 rh_bits,
  output logic [3:0]                 temp_bits,
  output logic                       supply_low_flag,
  output logic                       heater_on,
  output logic [HEAT_LVL_W-1:0]      heater_level,
  output logic                       no_hold,
  output logic                       thermistor_linearize_on,
  output logic                       adc_speed_select,
  output logic                       aux_input_buffer_on,
  output logic                       adc_reference_select,
  output logic                       meas_start,
  output logic                       irq
);

  typedef struct packed {
    logic [1:0]            res;
    logic [3:0]            rh_bits;
    logic [3:0]            t_bits;
    logic                  supply;
    logic                  heat_on;
    logic [HEAT_LVL_W-1:0] heat_lvl;
    logic                  no_hold;
    logic                  therm;
    logic                  speed;
    logic                  buf_on;
    logic                  vref;
    logic                  drive;
    logic [IRQ_W-1:0]      irq_st;
    logic [IRQ_W-1:0]      irq_en;
    logic                  irq;
    logic                  meas_go;
    logic [1:0]            strap_cnt;
    logic                  strap_done;
    logic                  addr_lsb;
    logic                  pin_oe;
    logic                  aw_have;
    logic [ADDR_W-1:0]     aw_addr;
    logic                  w_have;
    logic [7:0]            w_byte;
    logic                  w_lane0;
    logic                  aw_rdy;
    logic                  w_rdy;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  ar_rdy;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } sucr_state_t;

  localparam sucr_state_t RESET_STATE = '{
    res:      RST_RES,
    rh_bits:  RES_RH_BITS[0],
    t_bits:   RES_T_BITS[0],
    heat_on:  RST_HEAT_ON,
    heat_lvl: RST_HEAT_LVL,
    default:  '0
  };

  sucr_state_t       s_q;
  sucr_state_t       s_d;
  logic [3:0]        sync_level;
  logic [3:0]        sync_rise;
  logic              wr_go;
  logic              ar_go;
  logic              link_take;

  // Supply monitor, pin, link clock and request all cross into aclk here.
  sucr_sync_edge #(
    .W (4)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({meas_req_in, link_clk, pin_in, supply_low_in}),
    .level    (sync_level),
    .rise     (sync_rise)
  );

  // A write commits once both halves are held and no response is pending.
  assign wr_go     = s_q.aw_have & s_q.w_have & ~s_q.bvalid;
  assign ar_go     = s_axi_arvalid & s_q.ar_rdy;
  assign link_take = sync_rise[2] & sync_level[3];

  // Next-state logic: bus slave, register file, strap capture and events.
  always_comb
  begin
    logic [7:0]       rd_byte;
    logic [IRQ_W-1:0] set_ev;
    logic [IRQ_W-1:0] clr_ev;
    rd_byte = 8'h00;
    set_ev  = '0;
    clr_ev  = '0;
    s_d     = s_q;

    // The flag tracks the monitor live; no bus write reaches it.
    s_d.supply = sync_level[0];
    if (sync_rise[0])
    begin
      set_ev[IRQ_SUPPLY] = 1'b1;
    end

    // Catch the pin as address bit once the synchroniser holds real samples.
    if (!s_q.strap_done)
    begin
      if (s_q.strap_cnt == STRAP_WAIT)
      begin
        s_d.strap_done = 1'b1;
        s_d.addr_lsb   = sync_level[1];
        s_d.drive      = sync_level[1];
        s_d.pin_oe     = 1'b1;
      end
      else
      begin
        s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      end
    end

    // Internal measurements start only while both auxiliary mode bits are clear; otherwise the request only raises the measurement event.
    s_d.meas_go = 1'b0;
    if (link_take)
    begin
      if (s_q.no_hold || s_q.therm)
      begin
        set_ev[IRQ_MEAS] = 1'b1;
      end
      else
      begin
        s_d.meas_go = 1'b1;
      end
    end

    // Address and data phases are taken independently of each other.
    if (s_axi_awvalid && s_q.aw_rdy)
    begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.w_rdy)
    begin
      s_d.w_have  = 1'b1;
      s_d.w_byte  = s_axi_wdata[7:0];
      s_d.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end

    // Register writes; reserved bits have no storage and so ignore writes.
    if (wr_go)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      if (s_q.aw_addr == OFF_MEAS_CTRL)
      begin
        if (s_q.w_lane0)
        begin
          s_d.res     = {s_q.w_byte[BIT_RES_HI], s_q.w_byte[BIT_RES_LO]};
          s_d.heat_on = s_q.w_byte[BIT_HEAT_ON];
        end
      end
      else if (s_q.aw_addr == OFF_AUX_CTRL)
      begin
        if (s_q.w_lane0)
        begin
          s_d.no_hold = s_q.w_byte[BIT_NO_HOLD];
          s_d.therm   = s_q.w_byte[BIT_THERM];
          s_d.speed   = s_q.w_byte[BIT_SPEED];
          s_d.buf_on  = s_q.w_byte[BIT_BUF];
          s_d.vref    = s_q.w_byte[BIT_VREF];
          s_d.drive   = s_q.w_byte[BIT_DRIVE];
        end
      end
      else if (s_q.aw_addr == OFF_HEAT_CTRL)
      begin
        if (s_q.w_lane0)
        begin
          s_d.heat_lvl = s_q.w_byte[HEAT_LVL_W-1:0];
        end
      end
      else if (s_q.aw_addr == OFF_IRQ_CLEAR)
      begin
        if (s_q.w_lane0)
        begin
          clr_ev = s_q.w_byte[IRQ_W-1:0];
        end
      end
      else if (s_q.aw_addr == OFF_IRQ_ENABLE)
      begin
        if (s_q.w_lane0)
        begin
          s_d.irq_en = s_q.w_byte[IRQ_W-1:0];
        end
      end
      else if (s_q.aw_addr != OFF_IRQ_STATUS)
      begin
        // Such writes are the host's fault; flag them rather than corrupt state.
        s_d.bresp         = RESP_SLVERR;
        set_ev[IRQ_BADWR] = 1'b1;
      end
    end
    s_d.aw_rdy = ~s_d.aw_have & ~s_d.bvalid;
    s_d.w_rdy  = ~s_d.w_have & ~s_d.bvalid;

    // Decoded resolution follows the stored code.
    s_d.rh_bits = RES_RH_BITS[s_d.res];
    s_d.t_bits  = RES_T_BITS[s_d.res];

    // Set wins over clear so an event in the clearing cycle survives.
    s_d.irq_st = (s_q.irq_st & ~clr_ev) | set_ev;
    s_d.irq    = |(s_d.irq_st & s_d.irq_en);

    // Read path: reserved bits are merged in as constants.
    if (s_axi_rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (ar_go)
    begin
      s_d.rresp = RESP_OKAY;
      if (s_axi_araddr == OFF_MEAS_CTRL)
      begin
        rd_byte              = RESERVED_BITS_VAL_1 & RESERVED_BITS_MASK_1;
        rd_byte[BIT_RES_HI]  = s_q.res[1];
        rd_byte[BIT_SUPPLY]  = s_q.supply;
        rd_byte[BIT_HEAT_ON] = s_q.heat_on;
        rd_byte[BIT_RES_LO]  = s_q.res[0];
      end
      else if (s_axi_araddr == OFF_AUX_CTRL)
      begin
        rd_byte              = RESERVED_BITS_VAL_2 & RESERVED_BITS_MASK_2;
        rd_byte[BIT_NO_HOLD] = s_q.no_hold;
        rd_byte[BIT_THERM]   = s_q.therm;
        rd_byte[BIT_SPEED]   = s_q.speed;
        rd_byte[BIT_BUF]     = s_q.buf_on;
        rd_byte[BIT_VREF]    = s_q.vref;
        rd_byte[BIT_DRIVE]   = s_q.drive;
      end
      else if (s_axi_araddr == OFF_HEAT_CTRL)
      begin
        rd_byte = (RESERVED_BITS_VAL_3 & RESERVED_BITS_MASK_3) | {4'h0, s_q.heat_lvl};
      end
      else if (s_axi_araddr == OFF_IRQ_STATUS)
      begin
        rd_byte = {5'h00, s_q.irq_st};
      end
      else if (s_axi_araddr == OFF_IRQ_ENABLE)
      begin
        rd_byte = {5'h00, s_q.irq_en};
      end
      else if (s_axi_araddr != OFF_IRQ_CLEAR)
      begin
        s_d.rresp = RESP_SLVERR;
      end
      s_d.rvalid = 1'b1;
      s_d.rdata  = {24'h000000, rd_byte};
    end
    s_d.ar_rdy = ~s_d.rvalid;
  end

  // State register; reset brings every field to its documented value except drive and addr_lsb, which the strap capture loads from the pin.
  always_ff @(posedge aclk)
  begin
    if (!aresetn) s_q <= RESET_STATE;
    else          s_q <= s_d;
  end

  // Outputs come straight from the state register.
  assign s_axi_awready           = s_q.aw_rdy;
  assign s_axi_wready            = s_q.w_rdy;
  assign s_axi_bvalid            = s_q.bvalid;
  assign s_axi_bresp             = s_q.bresp;
  assign s_axi_arready           = s_q.ar_rdy;
  assign s_axi_rvalid            = s_q.rvalid;
  assign s_axi_rdata             = s_q.rdata;
  assign s_axi_rresp             = s_q.rresp;
  assign pin_out                 = s_q.drive;
  assign pin_oe                  = s_q.pin_oe;  // Input only until the strap is caught.
  assign addr_lsb                = s_q.addr_lsb;
  assign strap_done              = s_q.strap_done;
  assign resolution_select       = s_q.res;
  assign rh_bits                 = s_q.rh_bits;
  assign temp_bits               = s_q.t_bits;
  assign supply_low_flag         = s_q.supply;
  assign heater_on               = s_q.heat_on;
  assign heater_level            = s_q.heat_lvl;
  assign no_hold                 = s_q.no_hold;
  assign thermistor_linearize_on = s_q.therm;
  assign adc_speed_select        = s_q.speed;
  assign aux_input_buffer_on     = s_q.buf_on;
  assign adc_reference_select    = s_q.vref;
  assign meas_start              = s_q.meas_go;
  assign irq                     = s_q.irq;

  // Checks on the register bank.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reserved_bits_read_one: assert property (
    ar_go && s_axi_araddr == OFF_MEAS_CTRL |=> s_axi_rdata[5:3] == 3'h7 && s_axi_rdata[1]
  ) else $error("Reserved bits of the measurement register did not read one.");

  chk_res_decode: assert property (
    resolution_select == 2'h1 |-> rh_bits == 4'h8 && temp_bits == 4'hc
  ) else $error("Resolution code 01 decoded wrongly.");

  chk_supply_follow: assert property (
    $rose(sync_level[0]) |=> supply_low_flag ##1 (irq_st_supply_seen)
  ) else $error("Supply flag or its event did not follow the monitor.");

  chk_heater_write: assert property (
    wr_go && s_q.aw_addr == OFF_MEAS_CTRL && s_q.w_lane0 |=> heater_on == $past(s_q.w_byte[2])
  ) else $error("Heater enable did not take the written value.");

  chk_no_hold_read: assert property (
    ar_go && s_axi_araddr == OFF_AUX_CTRL |=> s_axi_rdata[6] == $past(no_hold)
  ) else $error("No-hold bit read back differs from its output.");

  chk_pin_drive: assert property (
    strap_done |-> pin_oe && pin_out == s_q.drive
  ) else $error("Pin is not driven from the drive bit.");

  chk_strap_copy: assert property (
    $rose(strap_done) |-> s_q.drive == addr_lsb && addr_lsb == $past(sync_level[1])
  ) else $error("Strap level was not copied into the drive bit.");

  chk_flag_rdonly: assert property (
    wr_go && s_q.aw_addr == OFF_MEAS_CTRL |=> supply_low_flag == $past(sync_level[0])
  ) else $error("A write reached the supply flag.");

  chk_reset_vals: assert property (
    !$past(aresetn) |-> heater_level == 4'h0 && resolution_select == 2'h0 && !heater_on
  ) else $error("Register reset values are wrong.");

  chk_meas_gate: assert property (
    meas_start |-> $past(!no_hold && !thermistor_linearize_on)
  ) else $error("Measurement started with auxiliary mode bits set.");

  logic irq_st_supply_seen;
  assign irq_st_supply_seen = s_q.irq_st[IRQ_SUPPLY];

  cov_write_meas: cover property (wr_go && s_q.aw_addr == OFF_MEAS_CTRL);
  cov_read_aux:   cover property (ar_go && s_axi_araddr == OFF_AUX_CTRL);
  cov_irq_high:   cover property ($rose(irq));
  cov_meas_start: cover property (meas_start);

endmodule : sucr_regs

// >>> sucr_link_host.sv
// Behavioural model of the measurement host on the link side of the register bank.
// Assumes the bench raises frame for as long as it wants requests to be issued.
`timescale 1ns/1ps
module sucr_link_host (
  input  wire logic frame,
  output logic      link_clk,
  output logic      meas_req
);
  // The link clock stands still low between frames and runs at 400 ns within one.
  initial
  begin
    link_clk = 1'b0;
    forever
    begin
      wait (frame);
      #200 link_clk = 1'b1;
      #200 link_clk = 1'b0;
    end
  end

  // The request leads the first link edge by half a period, so it is settled when sampled.
  assign meas_req = frame;
endmodule : sucr_link_host

// >>> testbench.sv
// Self-checking bench for the sensor user configuration register bank.
// Assumes sucr_pkg, sucr_regs and the link host model are compiled first.
`timescale 1ns/1ps
module testbench;
  import sucr_pkg::*;

  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, supply_low_in, link_clk, meas_req_in, pin_in, pin_out, pin_oe;
  logic        addr_lsb, strap_done, supply_low_flag, heater_on, no_hold, meas_start, irq;
  logic        thermistor_linearize_on, adc_speed_select, aux_input_buffer_on;
  logic        adc_reference_select, frame;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, rh_bits, temp_bits, heater_level;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resolution_select;
  int          failures, check_count, starts;

  sucr_regs u_sucr_regs (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_low_in, .link_clk,
    .meas_req_in, .pin_in, .pin_out, .pin_oe, .addr_lsb, .strap_done(),
    .resolution_select, .rh_bits, .temp_bits, .supply_low_flag, .heater_on,
    .heater_level, .no_hold, .thermistor_linearize_on, .adc_speed_select,
    .aux_input_buffer_on, .adc_reference_select, .meas_start, .irq
  );

  sucr_link_host u_sucr_link_host (.frame, .link_clk, .meas_req(meas_req_in));

  // Clock at 20 MHz.
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Counts measurement start pulses, which stand for one cycle only.
  always @(posedge aclk)
    if (meas_start === 1'b1) starts <= starts + 1;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      check_count++;
      if (g !== e)
      begin
        failures++;
        $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
    end
  endtask : chk

  // One write; each valid is held until its own ready, and bready until bvalid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    end
  endtask : wr

  // One read; the data is taken at the edge where rvalid is sampled high.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    end
  endtask : rd

  task automatic t_reset;
    begin
      chk("addr_lsb", 32'h1, {31'h0, addr_lsb});
      chk("pin drive", 32'h3, {30'h0, pin_out, pin_oe});
      rd(OFF_MEAS_CTRL, 32'h3a, RESP_OKAY);
      rd(OFF_AUX_CTRL, 32'h09, RESP_OKAY);
      rd(OFF_HEAT_CTRL, 32'h00, RESP_OKAY);
      rd(OFF_IRQ_ENABLE, 32'h00, RESP_OKAY);
    end
  endtask : t_reset

  // Every resolution code, with the heater bit following the low code bit.
  task automatic t_res;
    logic [3:0] rh_exp [4];
    logic [3:0] t_exp  [4];
    logic [1:0] k;
    begin
      rh_exp = '{4'hc, 4'h8, 4'ha, 4'hb};
      t_exp  = '{4'he, 4'hc, 4'hd, 4'hb};
      for (int c = 0; c < 4; c++)
      begin
        k = c[1:0];
        wr(OFF_MEAS_CTRL, {k[1], 1'b1, 3'h0, k[0], 1'b0, k[0]}, RESP_OKAY);
        rd(OFF_MEAS_CTRL, {24'h0, k[1], 4'h7, k[0], 1'b1, k[0]}, RESP_OKAY);
        chk("res", {28'h0, rh_exp[c]}, {28'h0, rh_bits});
        chk("res", {28'h0, t_exp[c]}, {28'h0, temp_bits});
        chk("heat", {31'h0, k[0]}, {31'h0, heater_on});
      end
    end
  endtask : t_res

  // Alternating patterns give each auxiliary bit both values.
  task automatic t_aux;
    begin
      wr(OFF_AUX_CTRL, 8'hd2, RESP_OKAY);
      rd(OFF_AUX_CTRL, 32'h5a, RESP_OKAY);
      chk("aux", 32'h55, {no_hold, thermistor_linearize_on, adc_speed_select,
        aux_input_buffer_on, adc_reference_select, pin_out, pin_oe});
      wr(OFF_AUX_CTRL, 8'h25, RESP_OKAY);
      rd(OFF_AUX_CTRL, 32'h2d, RESP_OKAY);
      chk("aux", 32'h2b, {no_hold, thermistor_linearize_on, adc_speed_select,
        aux_input_buffer_on, adc_reference_select, pin_out, pin_oe});
      wr(OFF_HEAT_CTRL, 8'hf9, RESP_OKAY);
      rd(OFF_HEAT_CTRL, 32'h09, RESP_OKAY);
      chk("heater_level", 32'h9, {28'h0, heater_level});
    end
  endtask : t_aux

  task automatic t_supply;
    begin
      wr(OFF_IRQ_ENABLE, 8'h01, RESP_OKAY);
      supply_low_in <= 1'b1;
      repeat (8) @(posedge aclk);
      chk("supply_low_flag", 32'h1, {31'h0, supply_low_flag});
      chk("irq", 32'h1, {31'h0, irq});
      wr(OFF_MEAS_CTRL, 8'h00, RESP_OKAY);
      rd(OFF_MEAS_CTRL, 32'h7a, RESP_OKAY);
      rd(OFF_IRQ_STATUS, 32'h01, RESP_OKAY);
      wr(OFF_IRQ_CLEAR, 8'h01, RESP_OKAY);
      rd(OFF_IRQ_CLEAR, 32'h00, RESP_OKAY);
      chk("irq", 32'h0, {31'h0, irq});
      supply_low_in <= 1'b0;
    end
  endtask : t_supply

  // Unmapped and read-only places, with the event masked and then unmasked.
  task automatic t_badwr;
    begin
      wr(8'h20, 8'hff, RESP_SLVERR);
      rd(8'h20, 32'h00, RESP_SLVERR);
      wr(OFF_IRQ_STATUS, 8'hff, RESP_OKAY);
      rd(OFF_IRQ_STATUS, 32'h02, RESP_OKAY);
      chk("irq", 32'h0, {31'h0, irq});
      wr(OFF_IRQ_ENABLE, 8'h02, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq", 32'h1, {31'h0, irq});
      wr(OFF_IRQ_CLEAR, 8'h02, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq", 32'h0, {31'h0, irq});
    end
  endtask : t_badwr

  // Requests are refused while correction is on, and taken once the host clears it.
  task automatic t_meas;
    int s0;
    begin
      wr(OFF_IRQ_ENABLE, 8'h04, RESP_OKAY);
      s0 = starts;
      frame <= 1'b1;
      repeat (40) @(posedge aclk);
      frame <= 1'b0;
      repeat (10) @(posedge aclk);
      chk("meas refused", 32'h0, starts - s0);
      chk("irq", 32'h1, {31'h0, irq});
      rd(OFF_IRQ_STATUS, 32'h04, RESP_OKAY);
      wr(OFF_AUX_CTRL, 8'h00, RESP_OKAY);
      wr(OFF_IRQ_CLEAR, 8'h04, RESP_OKAY);
      s0 = starts;
      frame <= 1'b1;
      repeat (40) @(posedge aclk);
      frame <= 1'b0;
      repeat (10) @(posedge aclk);
      chk("meas taken", 32'h1, {31'h0, starts > s0});
      rd(OFF_IRQ_STATUS, 32'h00, RESP_OKAY);
    end
  endtask : t_meas

  task automatic test_done;
    begin
      if (failures == 0 && check_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask : test_done

  // The pin strap level is tied high; only the low write strobe lane is used.
  initial
  begin
    aresetn       = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_araddr  = 8'h00;
    s_axi_wdata   = 32'h00000000;
    s_axi_wstrb   = 4'h1;
    supply_low_in = 1'b0;
    pin_in        = 1'b1;
    frame         = 1'b0;
    starts        = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    t_reset;
    t_res;
    t_aux;
    t_supply;
    t_badwr;
    t_meas;
    test_done;
  end

  // A hang is cut short well beyond the roughly 250 cycles the tests need.
  initial
  begin
    repeat (5000) @(posedge aclk);
    failures++;
    test_done;
  end
endmodule : testbench
